// ==== hdl/tx_irq_pkg.sv ====
// Constants for the transmit serializer interrupt status block
// Overview of operation
// - Underflow set when transmitter starves for data
// - Underflow only after one bit sent
// - Overflow set on reload before byte sent
// - Done set after last byte, bit sent
// - Status read clears underflow, overflow, done
// - Empty set when byte enters transmitter
// - Data register write clears empty flag
// - Bits 7:4 reserved, register read-only
// - Flag reads one when condition pending
// - Enable bit 0 gates empty interrupt
// - Enable bit 1 gates done interrupt
// - Flags poll regardless; zero outside transmit
package tx_irq_pkg;
   // Register offsets
   localparam logic [7:0] tx_status_addr = 8'h0E;
   localparam logic [7:0] tx_data_addr = 8'h0F;
   // Status field positions
   localparam int empty_bit = 0;
   localparam int done_bit = 1;
   localparam int overflow_bit = 2;
   localparam int underflow_bit = 3;
   // Reset values
   localparam logic [3:0] status_reset = 4'h0;
   localparam logic [7:0] data_reset = 8'h00;
   localparam logic [2:0] bit_count_reset = 3'h0;
   // Transmit bit period in core clocks
   localparam int bit_period_ns = 16000;
   localparam int clk_period_ns = 25;
   localparam int bit_cycles = bit_period_ns / clk_period_ns;
endpackage

// ==== hdl/tx_irq_sticky.sv ====
// Sticky flag with set-over-clear priority
`timescale 1ns/1ps
module tx_irq_sticky (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Controls
   input wire logic set_in,
   input wire logic clr_in,
   // State
   output logic flag
);
   // Set wins over a same-cycle clear so no event is lost
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flag <= 1'b0;
      end else if (set_in) begin
         flag <= 1'b1;
      end else if (clr_in) begin
         flag <= 1'b0;
      end
   end
endmodule

// ==== hdl/tx_serializer_irq_status.sv ====
// Transmit serializer with sticky interrupt status and request output
`timescale 1ns/1ps
module tx_serializer_irq_status #(
   parameter int bit_cycles = tx_irq_pkg::bit_cycles
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Register port (same clock domain)
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Mode and enables
   input wire logic tx_enable,
   input wire logic [1:0] tx_irq_enable,
   // Serial output and interrupt
   output logic tx_bit,
   output logic tx_active,
   output logic irq
);
   // Counter width for the bit period
   localparam int cw = $clog2(bit_cycles + 1);
   localparam logic [cw-1:0] last_tick = cw'(bit_cycles - 1);

   // State of the block apart from the sticky flags
   typedef struct packed {
      logic [7:0] hold;     // Holding register byte
      logic hold_full;      // Holding byte not yet taken
      logic [7:0] shift;    // Bits being sent
      logic [2:0] bit_cnt;  // Bit index in shift
      logic [cw-1:0] tick;  // Bit period counter
      logic shifting;       // Shifter busy
      logic sent_one;       // At least one bit sent
      logic [7:0] rdata;    // Read data register
      logic tx_bit;         // Serial output
      logic irq;            // Interrupt output
   } state_t;

   state_t st;
   state_t next_st;
   logic [3:0] flags;       // Sticky status
   logic [3:0] set_ev;      // Event pulses
   logic [3:0] clr_ev;      // Clear pulses
   logic data_wr;           // Host write to data register
   logic stat_rd;           // Host read of status register
   logic bit_end;           // Last tick of a bit period
   logic take;              // Shifter takes the holding byte

   // Access decode
   assign data_wr = reg_wr && (reg_addr == tx_irq_pkg::tx_data_addr);
   assign stat_rd = reg_rd && (reg_addr == tx_irq_pkg::tx_status_addr);
   assign bit_end = st.shifting && (st.tick == last_tick);
   // Transfer when idle or at the end of the last bit
   assign take = tx_enable && st.hold_full &&
      (!st.shifting || (bit_end && st.bit_cnt == 3'd7));

   // Sticky flags, one per event
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_flag
         tx_irq_sticky u_flag (
            .core_clk(core_clk),
            .rstn(rstn),
            .set_in(set_ev[gi]),
            .clr_in(clr_ev[gi]),
            .flag(flags[gi])
         );
      end
   endgenerate

   // Event and clear decode
   always_comb begin
      set_ev = 4'h0;
      clr_ev = 4'h0;
      // Leaving transmit mode wipes status
      if (!tx_enable) begin
         clr_ev = 4'hF;
      end else begin
         // Status read clears three flags
         if (stat_rd) begin
            clr_ev[tx_irq_pkg::underflow_bit] = 1'b1;
            clr_ev[tx_irq_pkg::overflow_bit] = 1'b1;
            clr_ev[tx_irq_pkg::done_bit] = 1'b1;
         end
         // Data write clears empty
         if (data_wr) begin
            clr_ev[tx_irq_pkg::empty_bit] = 1'b1;
         end
         // Reload while the old byte still waits; a same-cycle
         // transfer has already saved that byte, so no overflow then
         if (data_wr && st.hold_full && !take) begin
            set_ev[tx_irq_pkg::overflow_bit] = 1'b1;
         end
         // Byte moves into the shifter
         if (take) begin
            set_ev[tx_irq_pkg::empty_bit] = 1'b1;
         end
         // Byte finished, nothing waiting
         if (bit_end && st.bit_cnt == 3'd7 && !st.hold_full) begin
            set_ev[tx_irq_pkg::done_bit] = 1'b1;
            // Starved; the bit that just ended proves one went out
            set_ev[tx_irq_pkg::underflow_bit] = 1'b1;
         end
      end
   end

   // Next state
   always_comb begin
      next_st = st;
      // Host loads holding register
      if (data_wr) begin
         next_st.hold = reg_wdata;
         next_st.hold_full = 1'b1;
      end
      // Bit timing
      if (st.shifting) begin
         next_st.tick = bit_end ? '0 : st.tick + 1'b1;
      end
      if (bit_end) begin
         next_st.sent_one = 1'b1;
         next_st.shift = {1'b0, st.shift[7:1]};
         next_st.bit_cnt = st.bit_cnt + 3'd1;
         if (st.bit_cnt == 3'd7) begin
            next_st.shifting = 1'b0;
         end
      end
      // Load shifter from holding register, LSB first
      if (take) begin
         next_st.shift = st.hold;
         next_st.bit_cnt = tx_irq_pkg::bit_count_reset;
         next_st.tick = '0;
         next_st.shifting = 1'b1;
         next_st.hold_full = data_wr;
      end
      next_st.tx_bit = next_st.shifting ? next_st.shift[0] : 1'b0;
      // Outside transmit mode the shifter and serial output idle
      if (!tx_enable) begin
         next_st.shifting = 1'b0;
         next_st.sent_one = 1'b0;
         next_st.tx_bit = 1'b0;
      end
      // Status read data; reserved bits zero
      next_st.rdata = st.rdata;
      if (reg_rd) begin
         next_st.rdata = 8'h00;
         if (stat_rd && tx_enable) begin
            next_st.rdata = {4'h0, flags};
         end
      end
      // Interrupt request from enabled flags
      next_st.irq = (flags[tx_irq_pkg::empty_bit] &&
                     tx_irq_enable[0]) ||
                    (flags[tx_irq_pkg::done_bit] &&
                     tx_irq_enable[1]);
   end

   // State register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign reg_rdata = st.rdata;
   assign tx_bit = st.tx_bit;
   assign tx_active = st.shifting;
   assign irq = st.irq;

   // Overflow follows a reload of a full register
   property p_overflow;
      @(posedge core_clk) disable iff (!rstn)
      (data_wr && st.hold_full && !take && tx_enable) |=>
         flags[tx_irq_pkg::overflow_bit];
   endproperty
   a_overflow: assert property (p_overflow)
      else $error("overflow not flagged");

   // Write clears empty unless a load coincides
   property p_empty_clr;
      @(posedge core_clk) disable iff (!rstn)
      (data_wr && !set_ev[tx_irq_pkg::empty_bit]) |=>
         !flags[tx_irq_pkg::empty_bit];
   endproperty
   a_empty_clr: assert property (p_empty_clr)
      else $error("empty not cleared by write");

   // Read clears three flags
   property p_read_clr;
      @(posedge core_clk) disable iff (!rstn)
      (stat_rd && set_ev == 4'h0) |=> (flags[3:1] == 3'b000);
   endproperty
   a_read_clr: assert property (p_read_clr)
      else $error("status read did not clear");

   // Underflow never before a bit is sent
   property p_underflow_first;
      @(posedge core_clk) disable iff (!rstn)
      $rose(flags[tx_irq_pkg::underflow_bit]) |-> $past(bit_end);
   endproperty
   a_underflow_first: assert property (p_underflow_first)
      else $error("underflow without sent bit");

   // Done sets after last bit with empty holding register
   property p_done;
      @(posedge core_clk) disable iff (!rstn)
      (tx_enable && bit_end && st.bit_cnt == 3'd7 && !st.hold_full)
         |=> flags[tx_irq_pkg::done_bit];
   endproperty
   a_done: assert property (p_done)
      else $error("done not flagged");

   // Empty sets when shifter takes the byte
   property p_empty_set;
      @(posedge core_clk) disable iff (!rstn)
      (tx_enable && st.hold_full && !st.shifting) |=>
         flags[tx_irq_pkg::empty_bit] && st.shifting;
   endproperty
   a_empty_set: assert property (p_empty_set)
      else $error("empty not set on load");

   // Reserved bits read zero
   property p_reserved;
      @(posedge core_clk) disable iff (!rstn)
      reg_rdata[7:4] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bits nonzero");

   // Status zero outside transmit mode
   property p_idle_zero;
      @(posedge core_clk) disable iff (!rstn)
      !tx_enable |=> (flags == 4'h0);
   endproperty
   a_idle_zero: assert property (p_idle_zero)
      else $error("status not zero when idle");

   // Interrupt follows enabled flags by one cycle
   property p_irq;
      @(posedge core_clk) disable iff (!rstn)
      ((flags[0] && tx_irq_enable[0]) || (flags[1] && tx_irq_enable[1]))
         |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq missing");

   // No request without an enabled pending flag
   property p_irq_quiet;
      @(posedge core_clk) disable iff (!rstn)
      !((flags[0] && tx_irq_enable[0]) || (flags[1] && tx_irq_enable[1]))
         |=> !irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("irq without enabled flag");

   // Overflow stays clear while no byte is lost
   property p_overflow_quiet;
      @(posedge core_clk) disable iff (!rstn)
      (!(data_wr && st.hold_full && !take) &&
         !flags[tx_irq_pkg::overflow_bit]) |=>
         !flags[tx_irq_pkg::overflow_bit];
   endproperty
   a_overflow_quiet: assert property (p_overflow_quiet)
      else $error("overflow without lost byte");

   // Underflow sets when the shifter starves
   property p_underflow_set;
      @(posedge core_clk) disable iff (!rstn)
      (tx_enable && bit_end && st.bit_cnt == 3'd7 && !st.hold_full)
         |=> flags[tx_irq_pkg::underflow_bit];
   endproperty
   a_underflow_set: assert property (p_underflow_set)
      else $error("underflow not flagged");

   // Status read returns the flags as they stood
   property p_read_data;
      @(posedge core_clk) disable iff (!rstn)
      (stat_rd && tx_enable) |=>
         (reg_rdata == {4'h0, $past(flags)});
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("status read data wrong");

   // Reads outside transmit mode return zero
   property p_read_idle;
      @(posedge core_clk) disable iff (!rstn)
      (reg_rd && !tx_enable) |=> (reg_rdata == 8'h00);
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("read not zero when idle");

   // Read data stands until the next read; writes never touch it
   property p_rd_hold;
      @(posedge core_clk) disable iff (!rstn)
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data changed without read");

   // Main scenarios
   c_byte_sent: cover property (@(posedge core_clk) disable iff (!rstn)
      $rose(flags[tx_irq_pkg::done_bit]));
   c_overflow: cover property (@(posedge core_clk) disable iff (!rstn)
      $rose(flags[tx_irq_pkg::overflow_bit]));
   c_back_to_back: cover property (@(posedge core_clk) disable iff (!rstn)
      bit_end && st.bit_cnt == 3'd7 && st.hold_full);
   c_empty_irq: cover property (@(posedge core_clk) disable iff (!rstn)
      irq && tx_irq_enable[0]);
endmodule

// ==== testbench/tx_host_model.sv ====
// Host model that drives the register port of the transmit status block
`timescale 1ns/1ps
module tx_host_model (
   // Clock
   input wire logic core_clk,
   // Register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // Idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // One-cycle write strobe; address and data held through the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      // Released data shows the inverse, so stale bytes never look valid
      reg_wdata <= ~d;
   endtask
   // One-cycle read strobe; registered answer holds, taken next rising edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      d = reg_rdata;
   endtask
endmodule

// ==== testbench/test_tx_serializer_irq_status.sv ====
// Self-checking bench for the transmit serializer interrupt status block
`timescale 1ns/1ps
module test_tx_serializer_irq_status;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic tx_enable = 1'b0;
   logic [1:0] tx_irq_enable = 2'b00;
   logic reg_wr, reg_rd, tx_bit, tx_active, irq;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   // Short bit time keeps each byte at 32 clocks
   localparam int tb_bit_cycles = 4;
   // Serial capture state
   logic [7:0] rx_byte = 8'h00;
   int rx_phase = 0;
   int rx_bits = 0;
   int rx_count = 0;
   tx_serializer_irq_status #(.bit_cycles(tb_bit_cycles)) u_dut (
      .core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .tx_enable(tx_enable), .tx_irq_enable(tx_irq_enable),
      .tx_bit(tx_bit), .tx_active(tx_active), .irq(irq));
   tx_host_model u_host (
      .core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   // 40 MHz clock
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   // Verdict and end of run
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Compare with four-state equality
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Register read with expected value
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(a, d);
      check(d, exp);
   endtask
   // Hang guard, well above the roughly 120 clocks the run needs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         $display("ERROR %0t: timeout", $time);
         print_verdict();
      end
   end
   // Serial capture: one sample mid-bit, shifted in LSB first
   always @(posedge core_clk) begin
      if (tx_active !== 1'b1) begin
         rx_phase = 0;
         rx_bits = 0;
      end else begin
         if (rx_phase == tb_bit_cycles / 2 - 1) begin
            rx_byte = {tx_bit, rx_byte[7:1]};
            rx_bits++;
         end
         rx_phase = (rx_phase + 1) % tb_bit_cycles;
         // Overwritten byte is lost, so only the first and last go out
         if (rx_bits == 8) begin
            check(rx_byte, (rx_count == 0) ? 8'hA5 : 8'hC3);
            rx_count++;
            rx_bits = 0;
         end
      end
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      rdchk(8'h0E, 8'h00);
      tx_enable <= 1'b1;
      u_host.wr(8'h0F, 8'hA5);
      repeat (2) @(posedge core_clk);
      rdchk(8'h0E, 8'h01);
      check({7'h00, tx_active}, 8'h01);
      u_host.wr(8'h0F, 8'h3C);
      u_host.wr(8'h0F, 8'hC3);
      rdchk(8'h0E, 8'h04);
      rdchk(8'h0E, 8'h00);
      tx_irq_enable <= 2'b10;
      // Wait for the done request, bounded by two byte times and margin
      for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge core_clk);
      check({7'h00, irq}, 8'h01);
      check({7'h00, tx_active}, 8'h00);
      rdchk(8'h0E, 8'h0B);
      repeat (2) @(posedge core_clk);
      check({7'h00, irq}, 8'h00);
      tx_irq_enable <= 2'b01;
      repeat (3) @(posedge core_clk);
      check({7'h00, irq}, 8'h01);
      tx_irq_enable <= 2'b00;
      repeat (3) @(posedge core_clk);
      check({7'h00, irq}, 8'h00);
      rdchk(8'h0E, 8'h01);
      u_host.wr(8'h0E, 8'hFF);
      rdchk(8'h0E, 8'h01);
      rdchk(8'h10, 8'h00);
      tx_enable <= 1'b0;
      repeat (2) @(posedge core_clk);
      rdchk(8'h0E, 8'h00);
      check(rx_count[7:0], 8'h02);
      print_verdict();
   end
endmodule
